// >>> design/ipf_defs.vh
// Register offsets, field layout and reset values for the priority field block
`ifndef IPF_DEFS_VH
`define IPF_DEFS_VH
// Register byte offsets (word aligned)
`define IPF_OFS_CTRL3 8'h00
`define IPF_OFS_CTRL4 8'h04
`define IPF_OFS_CTRL5 8'h08
`define IPF_OFS_CTRL6 8'h0C
`define IPF_OFS_CTRL7 8'h10
`define IPF_OFS_CTRL8 8'h14
// Field positions (low bit of each 3-bit field)
`define IPF_FLD0_LSB 0
`define IPF_FLD1_LSB 4
`define IPF_FLD2_LSB 8
`define IPF_FLD3_LSB 12
// Field reset value: upper bit one, level 4
`define IPF_PRIO_RST 3'h4
// Implemented-bit masks per register
`define IPF_MASK_FULL 16'h7777
`define IPF_MASK_CTRL3 16'h0777
`define IPF_MASK_CTRL4 16'h7077
// Reset images per register
`define IPF_RST_FULL 16'h4444
`define IPF_RST_CTRL3 16'h0444
`define IPF_RST_CTRL4 16'h4044
// Request enables after reset: every field resets to a nonzero level
`define IPF_ACT_RST 22'h3FFFFF
`endif

// >>> design/ipf_interrupt_priority_fields.v
// Priority field registers for a group of interrupt sources, Wishbone slave
`timescale 1ns/1ps
`include "ipf_defs.vh"

module ipf_interrupt_priority_fields #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // Priority levels to arbitration
  output wire [2:0] dma_ch1_done_prio,
  output wire [2:0] conv1_done_prio,
  output wire [2:0] serial1_tx_prio,
  output wire [2:0] pin_change_prio,
  output wire [2:0] twowire1_master_prio,
  output wire [2:0] twowire1_slave_prio,
  output wire [2:0] capture8_prio,
  output wire [2:0] capture7_prio,
  output wire [2:0] conv2_done_prio,
  output wire [2:0] ext_irq1_prio,
  output wire [2:0] timer4_prio,
  output wire [2:0] compare4_prio,
  output wire [2:0] compare3_prio,
  output wire [2:0] dma_ch2_done_prio,
  output wire [2:0] serial2_tx_prio,
  output wire [2:0] serial2_rx_prio,
  output wire [2:0] ext_irq2_prio,
  output wire [2:0] timer5_prio,
  output wire [2:0] can1_event_prio,
  output wire [2:0] can1_rx_ready_prio,
  output wire [2:0] sync_serial2_event_prio,
  output wire [2:0] sync_serial2_error_prio,
  // Per-source request enable: registered, low one cycle after the field becomes 000
  output reg [21:0] srcActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [15:0] ctrl3_ff;
  reg [15:0] ctrl4_ff;
  reg [15:0] ctrl5_ff;
  reg [15:0] ctrl6_ff;
  reg [15:0] ctrl7_ff;
  reg [15:0] ctrl8_ff;

  // Address decode, used for both write and read paths
  function [5:0] decodeSel;
    input [AW-1:0] adr;
    begin
      decodeSel = 6'h00;
      case (adr)
        `IPF_OFS_CTRL3: decodeSel = 6'h01;
        `IPF_OFS_CTRL4: decodeSel = 6'h02;
        `IPF_OFS_CTRL5: decodeSel = 6'h04;
        `IPF_OFS_CTRL6: decodeSel = 6'h08;
        `IPF_OFS_CTRL7: decodeSel = 6'h10;
        `IPF_OFS_CTRL8: decodeSel = 6'h20;
        default: decodeSel = 6'h00;
      endcase
    end
  endfunction

  // Byte-lane merge with implemented-bit mask
  function [15:0] mergeWr;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0] sel;
    input [15:0] mask;
    reg [15:0] tmp;
    begin
      tmp = old;
      if (sel[0]) begin
        tmp[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
        tmp[15:8] = wdat[15:8];
      end
      mergeWr = tmp & mask;
    end
  endfunction

  wire reqValid = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [5:0] hit = decodeSel(wb_adr_i);
  wire doWr = reqValid & wb_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl3_ff <= `IPF_RST_CTRL3;
      ctrl4_ff <= `IPF_RST_CTRL4;
      ctrl5_ff <= `IPF_RST_FULL;
      ctrl6_ff <= `IPF_RST_FULL;
      ctrl7_ff <= `IPF_RST_FULL;
      ctrl8_ff <= `IPF_RST_FULL;
    end else if (doWr) begin
      // Masks keep unused bits zero
      if (hit[0]) begin
        ctrl3_ff <= mergeWr(ctrl3_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_CTRL3);
      end
      if (hit[1]) begin
        ctrl4_ff <= mergeWr(ctrl4_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_CTRL4);
      end
      if (hit[2]) begin
        ctrl5_ff <= mergeWr(ctrl5_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_FULL);
      end
      if (hit[3]) begin
        ctrl6_ff <= mergeWr(ctrl6_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_FULL);
      end
      if (hit[4]) begin
        ctrl7_ff <= mergeWr(ctrl7_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_FULL);
      end
      if (hit[5]) begin
        ctrl8_ff <= mergeWr(ctrl8_ff, wb_dat_i[15:0], wb_sel_i[1:0], `IPF_MASK_FULL);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after request, err for unmapped addresses

  reg [15:0] rdMux;
  always @* begin
    case (hit)
      6'h01: rdMux = ctrl3_ff;
      6'h02: rdMux = ctrl4_ff;
      6'h04: rdMux = ctrl5_ff;
      6'h08: rdMux = ctrl6_ff;
      6'h10: rdMux = ctrl7_ff;
      6'h20: rdMux = ctrl8_ff;
      default: rdMux = 16'h0000;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= reqValid & (|hit);
      wb_err_o <= reqValid & ~(|hit);
      wb_dat_o <= (reqValid & ~wb_we_i) ? {16'h0000, rdMux} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field forwarding: registers are flops, so outputs come straight from them

  assign dma_ch1_done_prio = ctrl3_ff[`IPF_FLD2_LSB +: 3];
  assign conv1_done_prio = ctrl3_ff[`IPF_FLD1_LSB +: 3];
  assign serial1_tx_prio = ctrl3_ff[`IPF_FLD0_LSB +: 3];
  assign pin_change_prio = ctrl4_ff[`IPF_FLD3_LSB +: 3];
  assign twowire1_master_prio = ctrl4_ff[`IPF_FLD1_LSB +: 3];
  assign twowire1_slave_prio = ctrl4_ff[`IPF_FLD0_LSB +: 3];
  assign capture8_prio = ctrl5_ff[`IPF_FLD3_LSB +: 3];
  assign capture7_prio = ctrl5_ff[`IPF_FLD2_LSB +: 3];
  assign conv2_done_prio = ctrl5_ff[`IPF_FLD1_LSB +: 3];
  assign ext_irq1_prio = ctrl5_ff[`IPF_FLD0_LSB +: 3];
  assign timer4_prio = ctrl6_ff[`IPF_FLD3_LSB +: 3];
  assign compare4_prio = ctrl6_ff[`IPF_FLD2_LSB +: 3];
  assign compare3_prio = ctrl6_ff[`IPF_FLD1_LSB +: 3];
  assign dma_ch2_done_prio = ctrl6_ff[`IPF_FLD0_LSB +: 3];
  assign serial2_tx_prio = ctrl7_ff[`IPF_FLD3_LSB +: 3];
  assign serial2_rx_prio = ctrl7_ff[`IPF_FLD2_LSB +: 3];
  assign ext_irq2_prio = ctrl7_ff[`IPF_FLD1_LSB +: 3];
  assign timer5_prio = ctrl7_ff[`IPF_FLD0_LSB +: 3];
  assign can1_event_prio = ctrl8_ff[`IPF_FLD3_LSB +: 3];
  assign can1_rx_ready_prio = ctrl8_ff[`IPF_FLD2_LSB +: 3];
  assign sync_serial2_event_prio = ctrl8_ff[`IPF_FLD1_LSB +: 3];
  assign sync_serial2_error_prio = ctrl8_ff[`IPF_FLD0_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Source enable: level is the binary code, 000 means never request

  wire [65:0] allPrio = {
    dma_ch1_done_prio, conv1_done_prio, serial1_tx_prio, pin_change_prio,
    twowire1_master_prio, twowire1_slave_prio, capture8_prio, capture7_prio,
    conv2_done_prio, ext_irq1_prio, timer4_prio, compare4_prio, compare3_prio,
    dma_ch2_done_prio, serial2_tx_prio, serial2_rx_prio, ext_irq2_prio,
    timer5_prio, can1_event_prio, can1_rx_ready_prio, sync_serial2_event_prio,
    sync_serial2_error_prio};

  wire [21:0] nxt_srcActive;
  genvar gi;
  generate
    for (gi = 0; gi < 22; gi = gi + 1) begin : gActive
      assign nxt_srcActive[gi] = |allPrio[gi*3 +: 3];
    end
  endgenerate

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      srcActive <= `IPF_ACT_RST;
    end else begin
      srcActive <= nxt_srcActive;
    end
  end

endmodule // ipf_interrupt_priority_fields

// >>> test/ipf_checker_asserts.sv
// Checker for the interrupt priority field block
`timescale 1ns/1ps
module ipf_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  // Watched levels
  input wire [2:0] pin_change_prio,
  input wire [2:0] capture8_prio,
  input wire [2:0] timer5_prio,
  input wire [21:0] srcActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_gaps; wb_ack_o && !wb_we_i |-> (wb_dat_o & 32'hFFFF8888) == 32'h0; endproperty
  a_gaps: assert property (p_gaps) else $error("unused bit read nonzero");
  property p_rd3; wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[15:11] == 5'h0; endproperty
  a_rd3: assert property (p_rd3) else $error("dma1 register top bits nonzero");
  property p_rd4; wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o[11:7] == 5'h0; endproperty
  a_rd4: assert property (p_rd4) else $error("pin change register gap nonzero");
  property p_wr; wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[1] |-> pin_change_prio == wb_dat_i[14:12];
  endproperty
  a_wr: assert property (p_wr) else $error("pin change level not written");
  property p_rst; $rose(rstn) |-> pin_change_prio == 3'h4 && timer5_prio == 3'h4; endproperty
  a_rst: assert property (p_rst) else $error("level after reset not 4");
  property p_act; srcActive[15] == ($past(capture8_prio) != 3'h0); endproperty
  a_act: assert property (p_act) else $error("request enable wrong");
  property p_hold; !$stable(timer5_prio) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_hold: assert property (p_hold) else $error("level changed without write");
  c_wr: cover property (wb_ack_o && wb_we_i);
  c_rd: cover property (wb_ack_o && !wb_we_i);
  c_err: cover property (wb_err_o);
endmodule // ipf_checker

bind ipf_interrupt_priority_fields ipf_checker u_chk (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pin_change_prio, .capture8_prio, .timer5_prio, .srcActive);

// >>> test/test_interrupt_priority_fields.sv
// Self-checking bench for the interrupt priority field block
`timescale 1ns/1ps
module test_interrupt_priority_fields;
  logic clk_sys = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, e;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [65:0] pr;
  logic [21:0] act;
  int err_total = 0, compares = 0;
  // Offset, reset image, write data, read back
  logic [15:0] rows [6][4] = '{'{16'h0000, 16'h0444, 16'hF9AB, 16'h0123}, '{16'h0004, 16'h4044, 16'hDFEF, 16'h5067},
    '{16'h0008, 16'h4444, 16'h8ABC, 16'h0234}, '{16'h000C, 16'h4444, 16'hF9EC, 16'h7164},
    '{16'h0010, 16'h4444, 16'h1357, 16'h1357}, '{16'h0014, 16'h4444, 16'h6420, 16'h6420}};
  ipf_interrupt_priority_fields u_dut (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .srcActive(act), .dma_ch1_done_prio(pr[65:63]),
    .conv1_done_prio(pr[62:60]), .serial1_tx_prio(pr[59:57]), .pin_change_prio(pr[56:54]),
    .twowire1_master_prio(pr[53:51]), .twowire1_slave_prio(pr[50:48]), .capture8_prio(pr[47:45]),
    .capture7_prio(pr[44:42]), .conv2_done_prio(pr[41:39]), .ext_irq1_prio(pr[38:36]), .timer4_prio(pr[35:33]),
    .compare4_prio(pr[32:30]), .compare3_prio(pr[29:27]), .dma_ch2_done_prio(pr[26:24]), .serial2_tx_prio(pr[23:21]),
    .serial2_rx_prio(pr[20:18]), .ext_irq2_prio(pr[17:15]), .timer5_prio(pr[14:12]), .can1_event_prio(pr[11:9]),
    .can1_rx_ready_prio(pr[8:6]), .sync_serial2_event_prio(pr[5:3]), .sync_serial2_error_prio(pr[2:0]));
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [65:0] g, input logic [65:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [3:0] s,
                    output logic [31:0] r, output logic f);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a[7:0];
    wb_sel_i <= s;
    wb_dat_i <= {16'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    if (n >= 20) begin
      err_total++;
      stop_test();
    end else begin
      r = wb_dat_o;
      f = wb_err_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      wb(1'h0, rows[i][0], 16'h0, 4'hF, q, e);
      chk(q, rows[i][1]);
      wb(1'h1, rows[i][0], rows[i][2], 4'hF, q, e);
      wb(1'h0, rows[i][0], 16'h0, 4'hF, q, e);
      chk(q, rows[i][3]);
    end
    chk(pr, 66'hA77709CE742EFD10);
    chk(act, 22'h3F7FFE);
    wb(1'h1, 16'h0010, 16'h7777, 4'h1, q, e);
    wb(1'h0, 16'h0010, 16'h0, 4'hF, q, e);
    chk(q, 16'h1377);
    wb(1'h0, 16'h0018, 16'h0, 4'hF, q, e);
    chk({q, e}, 33'h1);
    rstn <= 1'h0;
    @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    chk(pr, {22{3'h4}});
    chk(act, 22'h3FFFFF);
    stop_test();
  end
endmodule // test_interrupt_priority_fields
